/* File: logic/dct_timer.sv */
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// - two 16-bit down counters and two 16-bit reload/capture registers
// - control logic selects one of four modes, plus interrupt and pin control
// - each counter picks none, prescaled, event, pulse-accumulate or slow clock
// - 5-bit divisor and down counter divide system clock by divisor plus one
// - reset clears divisor and prescaler down counter
// - event clock counts rising or falling input edges as software selects
// - event and pulse-accumulate clocks stop counting in modes 2 and 4
// - pulse-accumulate ticks on prescaler pulse while input is at active level
// - active level of pulse-accumulate gating is software programmable
// - slow clock is synchronised and must run at most one-fourth system clock
// - slow clock source is blocked during power save
// - counters hold while system clock is stopped
// - after reset both counters have no clock until software configures them
// - mode 1 counter one reloads alternately from first and second registers
// - first reload after any restart comes from the first register
// - mode 1 toggles output pin on every counter one underflow when enabled
// - mode 1 sets separate pending flags for first and second reloads
// - counter two underflow sets its pending flag, interrupting when enabled
// - sources A, B, C share interrupt one; D drives interrupt two
module dct_timer #(
   parameter int unsigned CNT_W = dct_pkg::CNT_W,
   parameter int unsigned PS_W  = dct_pkg::PS_W
)(
   input  wire logic                       clk_sys,
   input  wire logic                       rst,
   input  wire logic                       ce,
   input  wire logic [dct_pkg::ADDR_W-1:0] addr,
   input  wire logic [dct_pkg::DATA_W-1:0] wdata,
   input  wire logic                       wr_stb,
   input  wire logic                       rd_stb,
   output logic      [dct_pkg::DATA_W-1:0] rdata,
   input  wire logic                       timer_pin_in,
   input  wire logic                       slow_clk,
   input  wire logic                       pwr_save,
   output logic                            timer_pin_out,
   output logic                            timer_irq1,
   output logic                            timer_irq2
);
   import dct_pkg::*;

   // ======================================================
   // parameter check
   if (CNT_W < 2 || CNT_W > DATA_W || PS_W < 1 || PS_W > CNT_W)
   begin : g_bad_param
      $error("dct_timer: unsupported width parameters");
   end

   // ======================================================
   // state
   logic [CNT_W-1:0]  cnt_q [2];
   logic [CNT_W-1:0]  cnt_d [2];
   logic [CNT_W-1:0]  rld   [2];
   logic [CNT_W-1:0]  rca_q;
   logic [CNT_W-1:0]  rcb_q;
   logic [PS_W-1:0]   prsc_q;
   logic [PS_W-1:0]   ps_cnt_q;
   logic [PS_W-1:0]   ps_cnt_d;
   dct_ctrl_t         ctrl_q;
   logic [IRQ_N-1:0]  ien_q;
   logic [IRQ_N-1:0]  pend_q;
   logic [IRQ_N-1:0]  pend_d;
   logic [IRQ_N-1:0]  pend_set;
   logic [IRQ_N-1:0]  pend_clr;
   logic              nxt_b_q;
   logic              nxt_b_d;
   logic              out_q;
   logic              out_d;
   logic              irq1_q;
   logic              irq2_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rd_mux;
   logic [2:0]        pin_s_q;
   logic [2:0]        slow_s_q;
   logic [1:0]        tick;
   logic [1:0]        unf;
   logic [1:0]        wr_cnt;
   logic              capt_mode;
   logic              pwm_mode;
   logic              pin_edge;
   logic              pacc_lvl;
   logic              slow_rise;
   logic              ps_tick;
   logic              restart;
   logic              tog_on;

   // ======================================================
   // clock source decode
   function automatic logic sel_tick(
      input dct_clk_sel_t sel,
      input logic         capt,
      input logic         ps,
      input logic         ev,
      input logic         lvl,
      input logic         sl,
      input logic         psave
   );
      logic t;
      t = 1'b0;
      case (sel)
         CS_PRESC: t = ps;
         CS_EVENT: t = ev && !capt;
         CS_PACC:  t = ps && lvl && !capt;
         CS_SLOW:  t = sl && !psave;
         default:  t = 1'b0;
      endcase
      return t;
   endfunction

   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] ofs
   );
      return a == ofs;
   endfunction

   // ======================================================
   // input synchronisers
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pin_s_q  <= 3'h0;
         slow_s_q <= 3'h0;
      end
      else if (ce)
      begin
         pin_s_q  <= {pin_s_q[1:0], timer_pin_in};
         slow_s_q <= {slow_s_q[1:0], slow_clk};
      end
   end

   assign pin_edge  = ctrl_q.edge_fall ? (pin_s_q[2] && !pin_s_q[1])
                                       : (pin_s_q[1] && !pin_s_q[2]);
   assign pacc_lvl  = pin_s_q[1] ^ ctrl_q.pacc_low;
   assign slow_rise = slow_s_q[1] && !slow_s_q[2];

   // ======================================================
   // prescaler
   assign ps_tick  = (ps_cnt_q == '0);
   assign ps_cnt_d = ps_tick ? prsc_q : ps_cnt_q - 1'b1;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ps_cnt_q <= PS_W'(PRSC_RST);
      end
      else if (ce)
      begin
         ps_cnt_q <= ps_cnt_d;
      end
   end

   // ======================================================
   // counters
   assign capt_mode = (ctrl_q.mode == MD_DCAP) || (ctrl_q.mode == MD_ICAP);
   assign pwm_mode  = (ctrl_q.mode == MD_PWM);
   assign tick[0]   = sel_tick(ctrl_q.clk1, capt_mode, ps_tick, pin_edge,
                               pacc_lvl, slow_rise, pwr_save);
   assign tick[1]   = sel_tick(ctrl_q.clk2, capt_mode, ps_tick, pin_edge,
                               pacc_lvl, slow_rise, pwr_save);
   assign wr_cnt[0] = wr_stb && hit(addr, OFS_CNT1);
   assign wr_cnt[1] = wr_stb && hit(addr, OFS_CNT2);
   assign rld[0]    = (pwm_mode && nxt_b_q) ? rcb_q : rca_q;
   assign rld[1]    = rcb_q;

   for (genvar gi = 0; gi < 2; gi++)
   begin : g_cnt
      assign unf[gi]   = tick[gi] && (cnt_q[gi] == '0);
      assign cnt_d[gi] = wr_cnt[gi] ? wdata[CNT_W-1:0]
                       : unf[gi]    ? rld[gi]
                       : tick[gi]   ? cnt_q[gi] - 1'b1
                       : cnt_q[gi];

      always_ff @(posedge clk_sys or posedge rst)
      begin
         if (rst)
         begin
            cnt_q[gi] <= CNT_W'(CNT_RST);
         end
         else if (ce)
         begin
            cnt_q[gi] <= cnt_d[gi];
         end
      end
   end

   // ======================================================
   // alternating reload and output pin
   assign restart = !pwm_mode || (ctrl_q.clk1 == CS_NONE);
   assign nxt_b_d = restart ? 1'b0 : (unf[0] ? !nxt_b_q : nxt_b_q);
   assign tog_on  = ctrl_q.tog_en && (ctrl_q.mode != MD_DCAP);
   assign out_d   = !tog_on ? ctrl_q.out_init
                  : (unf[0] ? !out_q : out_q);

   // ======================================================
   // pending flags, set wins over clear
   assign pend_set[PND_A] = unf[0] && pwm_mode && !nxt_b_q;
   assign pend_set[PND_B] = unf[0] && pwm_mode && nxt_b_q;
   assign pend_set[PND_C] = unf[0] && !pwm_mode;
   assign pend_set[PND_D] = unf[1];
   assign pend_clr = (wr_stb && hit(addr, OFS_PEND)) ? wdata[IRQ_N-1:0] : '0;
   assign pend_d   = pend_set | (pend_q & ~pend_clr);

   // ======================================================
   // register writes
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rca_q   <= CNT_W'(RC_RST);
         rcb_q   <= CNT_W'(RC_RST);
         prsc_q  <= PS_W'(PRSC_RST);
         ctrl_q  <= dct_ctrl_t'(CTRL_RST);
         ien_q   <= IEN_RST;
      end
      else if (ce && wr_stb)
      begin
         if (hit(addr, OFS_RCA))
         begin
            rca_q <= wdata[CNT_W-1:0];
         end
         if (hit(addr, OFS_RCB))
         begin
            rcb_q <= wdata[CNT_W-1:0];
         end
         if (hit(addr, OFS_PRSC))
         begin
            prsc_q <= wdata[PS_W-1:0];
         end
         if (hit(addr, OFS_CTRL))
         begin
            ctrl_q <= dct_ctrl_t'(wdata[CTRL_W-1:0]);
         end
         if (hit(addr, OFS_IEN))
         begin
            ien_q <= wdata[IRQ_N-1:0];
         end
      end
   end

   // ======================================================
   // status, pin and interrupt flops
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         nxt_b_q <= 1'b0;
         out_q   <= 1'b0;
         pend_q  <= PEND_RST;
         irq1_q  <= 1'b0;
         irq2_q  <= 1'b0;
      end
      else if (ce)
      begin
         nxt_b_q <= nxt_b_d;
         out_q   <= out_d;
         pend_q  <= pend_d;
         irq1_q  <= |(pend_q & ien_q & IRQ1_MASK);
         irq2_q  <= pend_q[PND_D] && ien_q[PND_D];
      end
   end

   // ======================================================
   // read port
   assign rd_mux =
        hit(addr, OFS_CNT1) ? DATA_W'(cnt_q[0])
      : hit(addr, OFS_CNT2) ? DATA_W'(cnt_q[1])
      : hit(addr, OFS_RCA)  ? DATA_W'(rca_q)
      : hit(addr, OFS_RCB)  ? DATA_W'(rcb_q)
      : hit(addr, OFS_PRSC) ? DATA_W'(prsc_q)
      : hit(addr, OFS_CTRL) ? DATA_W'(ctrl_q)
      : hit(addr, OFS_IEN)  ? DATA_W'(ien_q)
      : hit(addr, OFS_PEND) ? DATA_W'({nxt_b_q, out_q, pend_q})
      : '0;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= '0;
      end
      else if (ce)
      begin
         rdata_q <= rd_stb ? rd_mux : '0;
      end
   end

   assign rdata         = rdata_q;
   assign timer_pin_out = out_q;
   assign timer_irq1    = irq1_q;
   assign timer_irq2    = irq2_q;

   // ======================================================
   // assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_prescale_reload: assert property (
      ce && ps_tick |=> ps_cnt_q == $past(prsc_q))
      else $error("prescaler did not reload divisor");

   a_reset_clear: assert property (
      $fell(rst) |-> prsc_q == '0 && ps_cnt_q == '0)
      else $error("prescaler not clear after reset");

   a_freeze_hold: assert property (
      !ce |=> $stable(cnt_q[0]) && $stable(cnt_q[1]) && $stable(out_q))
      else $error("state moved while clock enable low");

   a_capture_block: assert property (
      capt_mode |-> !((ctrl_q.clk1 inside {CS_EVENT, CS_PACC}) && tick[0])
                 && !((ctrl_q.clk2 inside {CS_EVENT, CS_PACC}) && tick[1]))
      else $error("event source ticked in capture mode");

   a_pacc_gate: assert property (
      ctrl_q.clk2 == CS_PACC && tick[1] |-> ps_tick && pacc_lvl)
      else $error("pulse accumulate tick without gate");

   a_slow_psave: assert property (
      pwr_save |-> !(ctrl_q.clk1 == CS_SLOW && tick[0])
                && !(ctrl_q.clk2 == CS_SLOW && tick[1]))
      else $error("slow clock used during power save");

   a_down_count: assert property (
      ce && tick[0] && cnt_q[0] != '0 && !wr_cnt[0]
      |=> cnt_q[0] == $past(cnt_q[0]) - 1'b1)
      else $error("counter one did not decrement");

   a_alt_reload: assert property (
      ce && unf[0] && pwm_mode && !nxt_b_q && !wr_cnt[0]
      |=> cnt_q[0] == $past(rca_q) && nxt_b_q)
      else $error("first reload not from first register");

   a_restart_first: assert property (
      ce && restart |=> !nxt_b_q)
      else $error("restart left second reload selected");

   a_pin_toggle: assert property (
      ce && unf[0] && tog_on |=> out_q != $past(out_q))
      else $error("output pin missed toggle");

   a_pend_set: assert property (
      ce && unf[0] && pwm_mode && nxt_b_q |=> pend_q[PND_B])
      else $error("second reload pending not set");

   a_irq_route: assert property (
      ce && pend_q[PND_D] && ien_q[PND_D] |=> timer_irq2)
      else $error("source D did not raise interrupt two");

   a_read_once: assert property (
      ce && !rd_stb |=> rdata == '0)
      else $error("read data outside read slot");

   a_cnt2_reload: assert property (
      ce && unf[1] && !wr_cnt[1] |=> cnt_q[1] == $past(rcb_q) && pend_q[PND_D])
      else $error("counter two underflow did not reload and pend");

   a_pend_other: assert property (
      ce && unf[0] && !pwm_mode |=> pend_q[PND_C])
      else $error("counter one underflow outside mode 1 not pending");

   a_irq_one: assert property (
      ce && |(pend_q & ien_q & IRQ1_MASK) |=> timer_irq1)
      else $error("sources A to C did not raise interrupt one");

   c_pwm_cycle: cover property (
      unf[0] && pwm_mode && !nxt_b_q ##[1:200] unf[0] && pwm_mode && nxt_b_q);
   c_cnt2_irq: cover property (unf[1] ##[1:4] timer_irq2);
   c_pacc_tick: cover property (ctrl_q.clk2 == CS_PACC && tick[1]);
   c_event_tick: cover property (ctrl_q.clk2 == CS_EVENT && tick[1]);

endmodule

/* File: shared/dct_pkg.sv */
package dct_pkg;

   // ======================================================
   // widths
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned PS_W   = 5;
   localparam int unsigned CTRL_W = 12;
   localparam int unsigned IRQ_N  = 4;

   // ======================================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CNT1 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CNT2 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RCA  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RCB  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PRSC = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IEN  = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PEND = 8'h1C;

   // ======================================================
   // pending bit positions
   localparam int unsigned PND_A = 0;
   localparam int unsigned PND_B = 1;
   localparam int unsigned PND_C = 2;
   localparam int unsigned PND_D = 3;
   localparam int unsigned STS_OUT = 4;
   localparam int unsigned STS_NXB = 5;
   localparam logic [IRQ_N-1:0] IRQ1_MASK = 4'h7;

   // ======================================================
   // reset values
   localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
   localparam logic [CNT_W-1:0]  RC_RST   = 16'h0000;
   localparam logic [PS_W-1:0]   PRSC_RST = 5'h00;
   localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
   localparam logic [IRQ_N-1:0]  IEN_RST  = 4'h0;
   localparam logic [IRQ_N-1:0]  PEND_RST = 4'h0;

   // ======================================================
   // modes and clock sources
   typedef enum logic [1:0] {
      MD_PWM  = 2'h0,
      MD_DCAP = 2'h1,
      MD_DUAL = 2'h2,
      MD_ICAP = 2'h3
   } dct_mode_t;

   typedef enum logic [2:0] {
      CS_NONE  = 3'h0,
      CS_PRESC = 3'h1,
      CS_EVENT = 3'h2,
      CS_PACC  = 3'h3,
      CS_SLOW  = 3'h4
   } dct_clk_sel_t;

   typedef struct packed {
      logic         pacc_low;
      logic         edge_fall;
      logic         out_init;
      logic         tog_en;
      dct_clk_sel_t clk2;
      dct_clk_sel_t clk1;
      dct_mode_t    mode;
   } dct_ctrl_t;

endpackage

/* File: tb/dct_far_end.sv */
`timescale 1ns/10ps
// ==========================================
// external signals on the timer pins
module dct_far_end (
   input  wire logic clk_sys,
   output logic      timer_pin_in,
   output logic      slow_clk
);
   initial
   begin
      timer_pin_in = 1'b0;
      slow_clk     = 1'b0;
   end

   // drive the input pin to a level for n clocks
   task automatic hold(input logic l, input int n);
      @(posedge clk_sys);
      timer_pin_in <= l;
      repeat (n - 1) @(posedge clk_sys);
   endtask

   task automatic set_level(input logic l);
      hold(l, 2);
   endtask

   task automatic pulses(input int n);
      repeat (n)
      begin
         set_level(!timer_pin_in);
         set_level(!timer_pin_in);
      end
   endtask

   // slow clock at one eighth of clk_sys, stopped between bursts
   task automatic slow_pulses(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         slow_clk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         slow_clk <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
   endtask
endmodule

/* File: tb/tb_dct_timer.sv */
`timescale 1ns/10ps
module tb_dct_timer;
   import dct_pkg::*;
   logic              clk_sys  = 1'b0;
   logic              rst;
   logic              ce;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr_stb;
   logic              rd_stb;
   logic              pwr_save;
   logic [DATA_W-1:0] rdata;
   logic              timer_pin_in;
   logic              slow_clk;
   logic              timer_pin_out;
   logic              timer_irq1;
   logic              timer_irq2;
   logic              prev_out = 1'b0;
   int                bad_count  = 0;
   int                num_checks = 0;
   int                cyc = 0;
   int                tq[$];
   int                a_v, b_v, p_v, c2, m;
   logic [ADDR_W-1:0] offs[9] = '{OFS_CNT1, OFS_CNT2, OFS_RCA, OFS_RCB, OFS_PRSC,
                                  OFS_CTRL, OFS_IEN, OFS_PEND, 8'h20};
   dct_mode_t         md[4]   = '{MD_PWM, MD_DCAP, MD_DUAL, MD_ICAP};

   always #12.5 clk_sys = ~clk_sys;

   dct_timer dct_timer_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .timer_pin_in(timer_pin_in), .slow_clk(slow_clk), .pwr_save(pwr_save),
      .timer_pin_out(timer_pin_out), .timer_irq1(timer_irq1), .timer_irq2(timer_irq2));

   dct_far_end dct_far_end_i (.clk_sys(clk_sys), .timer_pin_in(timer_pin_in),
      .slow_clk(slow_clk));

   // ==========================================
   // timeout and toggle recorder
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      prev_out <= timer_pin_out;
      if (timer_pin_out !== prev_out)
         tq.push_back(cyc);
      if (cyc == 20000)
      begin
         bad_count++;
         final_report();
      end
   end

   // ==========================================
   // helpers
   task automatic final_report();
      if (bad_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string n);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 chk(n, e, rdata);
   endtask

   function automatic logic [DATA_W-1:0] ctl(dct_mode_t md_v, dct_clk_sel_t k1,
      dct_clk_sel_t k2, logic tg, logic fe, logic pl);
      dct_ctrl_t c;
      c = '{pacc_low: pl, edge_fall: fe, out_init: 1'b0, tog_en: tg,
            clk2: k2, clk1: k1, mode: md_v};
      return {20'h0, c};
   endfunction

   // reference counter two: a tick at zero reloads
   function automatic int nxt(int v, int rl);
      return (v == 0) ? rl : v - 1;
   endfunction

   // ==========================================
   // main sequence
   initial
   begin
      rst      <= 1'b1;
      ce       <= 1'b1;
      addr     <= '0;
      wdata    <= '0;
      wr_stb   <= 1'b0;
      rd_stb   <= 1'b0;
      pwr_save <= 1'b0;
      void'($urandom(32'h11BEC75C));
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (offs[i]) rdc(offs[i], '0, "reset value");
      // pwm runs, each restarted from a stopped clock selection
      for (int r = 0; r < 2; r++)
      begin
         a_v = $urandom_range(6, 1);
         b_v = $urandom_range(6, 1);
         p_v = $urandom_range(3, 0);
         wr(OFS_IEN, (r == 0) ? 32'h9 : 32'h8);
         wr(OFS_RCA, a_v);
         wr(OFS_RCB, b_v);
         wr(OFS_PRSC, p_v);
         wr(OFS_CNT1, 0);
         tq.delete();
         wr(OFS_CTRL, ctl(MD_PWM, CS_PRESC, CS_NONE, 1'b1, 1'b0, 1'b0));
         for (int w = 0; w < 2000 && tq.size() < 4; w++) @(posedge clk_sys);
         wr(OFS_CTRL, ctl(MD_PWM, CS_NONE, CS_NONE, 1'b0, 1'b0, 1'b0));
         chk("toggles seen", 1, tq.size() >= 4);
         if (tq.size() >= 4)
         begin
            chk("first interval", (a_v + 1) * (p_v + 1), tq[1] - tq[0]);
            chk("second interval", (b_v + 1) * (p_v + 1), tq[2] - tq[1]);
            chk("third interval", (a_v + 1) * (p_v + 1), tq[3] - tq[2]);
         end
         rdc(OFS_PEND, 32'h3, "pending after pwm");
         chk("irq one", (r == 0), timer_irq1);
         wr(OFS_PEND, 32'hF);
         rdc(OFS_PEND, 32'h0, "pending cleared");
         chk("irq one cleared", 0, timer_irq1);
      end
      // event clock on counter two, both edges, ending in an underflow
      for (int f = 0; f < 2; f++)
      begin
         c2 = 2;
         wr(OFS_CNT2, c2);
         wr(OFS_CTRL, ctl(MD_PWM, CS_NONE, CS_EVENT, 1'b0, f[0], 1'b0));
         dct_far_end_i.set_level(1'b1);
         repeat (4) @(posedge clk_sys);
         if (f == 0)
            c2 = nxt(c2, b_v);
         rdc(OFS_CNT2, c2, "count after rise");
         dct_far_end_i.set_level(1'b0);
         repeat (4) @(posedge clk_sys);
         if (f == 1)
            c2 = nxt(c2, b_v);
         rdc(OFS_CNT2, c2, "count after fall");
         dct_far_end_i.pulses(2);
         repeat (4) @(posedge clk_sys);
         c2 = nxt(nxt(c2, b_v), b_v);
         rdc(OFS_CNT2, c2, "count after underflow");
         rdc(OFS_PEND, 32'h8, "pending two");
         chk("irq two", 1, timer_irq2);
         wr(OFS_PEND, 32'h8);
      end
      // event clock across all modes
      foreach (md[i])
      begin
         wr(OFS_CNT2, 20);
         wr(OFS_CTRL, ctl(md[i], CS_PRESC, CS_EVENT, 1'b0, 1'b0, 1'b0));
         dct_far_end_i.pulses(3);
         repeat (4) @(posedge clk_sys);
         rdc(OFS_CNT2, (md[i] == MD_DCAP || md[i] == MD_ICAP) ? 20 : 17, "mode event");
      end
      // pulse accumulate with both gate levels
      wr(OFS_PRSC, 0);
      for (int l = 0; l < 2; l++)
      begin
         dct_far_end_i.set_level(l[0]);
         wr(OFS_CTRL, ctl(MD_PWM, CS_NONE, CS_PACC, 1'b0, 1'b0, l[0]));
         wr(OFS_CNT2, 100);
         repeat (8) @(posedge clk_sys);
         rdc(OFS_CNT2, 100, "gate idle");
         m = $urandom_range(10, 3);
         dct_far_end_i.hold(!l[0], m);
         dct_far_end_i.hold(l[0], 6);
         rdc(OFS_CNT2, 100 - m, "gate count");
      end
      // slow clock, power save and a stopped system clock
      wr(OFS_CNT2, 50);
      wr(OFS_CTRL, ctl(MD_PWM, CS_NONE, CS_SLOW, 1'b0, 1'b0, 1'b0));
      dct_far_end_i.slow_pulses(5);
      repeat (4) @(posedge clk_sys);
      rdc(OFS_CNT2, 45, "slow count");
      @(posedge clk_sys);
      pwr_save <= 1'b1;
      dct_far_end_i.slow_pulses(3);
      repeat (4) @(posedge clk_sys);
      rdc(OFS_CNT2, 45, "power save count");
      @(posedge clk_sys);
      pwr_save <= 1'b0;
      ce <= 1'b0;
      dct_far_end_i.slow_pulses(3);
      @(posedge clk_sys);
      ce <= 1'b1;
      rdc(OFS_CNT2, 45, "frozen count");
      final_report();
   end
endmodule
